// file: src/spr_regs.svh
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// register offsets (byte addresses, one word each)
`define SPR_CTRL_OFS 8'h00
`define SPR_STAT_OFS 8'h04
`define SPR_CFG_OFS 8'h08
`define SPR_DIV_OFS 8'h0C

// control register fields
`define SPR_CTRL_TX_SYS 0
`define SPR_CTRL_RX_SYS 1
`define SPR_CTRL_TX_PATH 2
`define SPR_CTRL_RX_PATH 3
`define SPR_CTRL_RST 4'h0

// status register fields
`define SPR_STAT_TX_DONE 0
`define SPR_STAT_RX_DONE 1
`define SPR_STAT_TX_PLL 2
`define SPR_STAT_RX_PLL 3

// sequence timing, nanoseconds and derived cycles at 100 ns
`define SPR_CLK_NS 100
`define SPR_PLL_RST_NS 1000
`define SPR_PATH_RST_NS 500
`define SPR_PLL_RST_CYC ((`SPR_PLL_RST_NS + `SPR_CLK_NS - 1) / `SPR_CLK_NS)
`define SPR_PATH_RST_CYC ((`SPR_PATH_RST_NS + `SPR_CLK_NS - 1) / `SPR_CLK_NS)

// line-rate divide ratios for core and user clocks
`define SPR_DIV_32B 8'h28
`define SPR_DIV_64B 8'h42
`define SPR_USR_DIV_HI 8'h21
`define SPR_USR_DIV_UHS 8'h42

`endif

// file: src/spr_pkg.sv
package spr_pkg;
    typedef enum logic [1:0] {
        SPR_DW_32,
        SPR_DW_64
    } spr_width_type;

    typedef enum logic [1:0] {
        SPR_XCVR_LEGACY,
        SPR_XCVR_HS3,
        SPR_XCVR_HS4,
        SPR_XCVR_UHS
    } spr_xcvr_type;

    typedef enum {
        SPR_IDLE,
        SPR_PLL_HOLD,
        SPR_PLL_WAIT,
        SPR_PATH_HOLD,
        SPR_PATH_WAIT,
        SPR_DONE
    } spr_state_type;

    typedef struct packed {
        logic sys_req;
        logic path_req;
        logic pll_lock;
        logic path_ready;
    } spr_seq_in_type;

    typedef struct packed {
        logic pll_reset;
        logic path_reset;
        logic done;
        logic busy;
    } spr_seq_out_type;
endpackage

// file: src/spr_seq.sv
`include "spr_regs.svh"

module spr_seq #(
    parameter int PLL_CYC = `SPR_PLL_RST_CYC,
    parameter int PATH_CYC = `SPR_PATH_RST_CYC
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire spr_pkg::spr_seq_in_type seq_i,
    output spr_pkg::spr_seq_out_type seq_o
);
    spr_pkg::spr_state_type state;
    spr_pkg::spr_state_type next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    wire cnt_end = (cnt == 8'h00);

    always_comb begin
        next_state = state;
        next_cnt = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
        if (seq_i.sys_req) begin
            next_state = spr_pkg::SPR_PLL_HOLD; // RQ18
            next_cnt = 8'(PLL_CYC);
        end else if (seq_i.path_req) begin
            next_state = spr_pkg::SPR_PATH_HOLD; // RQ16 RQ17
            next_cnt = 8'(PATH_CYC);
        end else begin
            case (state)
                spr_pkg::SPR_PLL_HOLD: if (cnt_end) next_state = spr_pkg::SPR_PLL_WAIT;
                spr_pkg::SPR_PLL_WAIT: if (seq_i.pll_lock) begin
                    next_state = spr_pkg::SPR_PATH_HOLD; // RQ18
                    next_cnt = 8'(PATH_CYC);
                end
                spr_pkg::SPR_PATH_HOLD: if (cnt_end) next_state = spr_pkg::SPR_PATH_WAIT;
                spr_pkg::SPR_PATH_WAIT: if (seq_i.path_ready) next_state = spr_pkg::SPR_DONE;
                spr_pkg::SPR_IDLE: next_state = spr_pkg::SPR_IDLE;
                spr_pkg::SPR_DONE: next_state = spr_pkg::SPR_DONE;
                default: next_state = spr_pkg::SPR_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= spr_pkg::SPR_IDLE;
            cnt <= 8'h00;
            seq_o <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            seq_o.pll_reset <= (next_state == spr_pkg::SPR_PLL_HOLD);
            seq_o.path_reset <= (next_state == spr_pkg::SPR_PLL_HOLD)
                || (next_state == spr_pkg::SPR_PLL_WAIT)
                || (next_state == spr_pkg::SPR_PATH_HOLD);
            seq_o.done <= (next_state == spr_pkg::SPR_DONE); // RQ19
            seq_o.busy <= (next_state != spr_pkg::SPR_DONE)
                && (next_state != spr_pkg::SPR_IDLE);
        end
    end

    done_drop_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (seq_i.sys_req || seq_i.path_req) |=> !seq_o.done) // RQ19
        else $error("done stayed high after a new request");

    sequence pll_phase_s;
        seq_i.sys_req ##1 seq_o.pll_reset;
    endsequence
    pll_first_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pll_phase_s |-> seq_o.path_reset) // RQ18
        else $error("datapath not held during pll reset");

    path_only_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (seq_i.path_req && !seq_i.sys_req) |=> !seq_o.pll_reset && seq_o.path_reset) // RQ16
        else $error("path reset touched the pll");

    pll_len_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(seq_o.pll_reset) && !seq_i.sys_req |=> seq_o.pll_reset || seq_i.sys_req
            || (PLL_CYC < 2)) // RQ18
        else $error("pll reset pulse too short");
endmodule

// file: src/spr_top.sv
// Contract
// RQ1: eight build variants from management, shared pll and debug options.
// RQ2: debug ports drop controls already held in management registers.
// RQ3: pll reconfiguration port reachable only via management, shared pll selected.
// RQ4: newer family with management and shared pll shows both reference clocks.
// RQ5: as embedded sub-core the management port is forced off.
// RQ6: 32-bit variant pairs with older link core only.
// RQ7: 32-bit variant moves four bytes per core clock, line rate over 40.
// RQ8: 64-bit variant moves eight bytes plus header, line rate over 66.
// RQ9: 64-bit variant supports 64b/66b encoding only.
// RQ10: third and fourth generation user clock is line rate over 33.
// RQ11: ultra-high-speed user clock is line rate over 66.
// RQ12: reset sequencers run on the reconfiguration port clock.
// RQ13: integrator gives two reference clocks when both plls are used.
// RQ14: management clock is asynchronous; every crossing is synchronised.
// RQ15: transmit and receive have separate system and datapath resets.
// RQ16: transmit path reset resets only the transmit datapath, then done.
// RQ17: receive path reset resets only the receive datapath, then done.
// RQ18: system reset resets the plls then the datapath, then done.
// RQ19: done falls when a new sequence starts and stays low until it ends.
// RQ20: all four reset inputs are synchronised before starting a sequence.
`include "spr_regs.svh"

module spr_top #(
    parameter bit MGMT_EN = 1'b1,
    parameter bit SHARED_PLL_EN = 1'b1,
    parameter bit DEBUG_EN = 1'b0,
    parameter bit SUB_CORE = 1'b0,
    parameter bit SHARED_PLL_SEL = 1'b1,
    parameter bit BOTH_PLL_SEL = 1'b0,
    parameter spr_pkg::spr_width_type DATA_WIDTH = spr_pkg::SPR_DW_32,
    parameter spr_pkg::spr_xcvr_type XCVR = spr_pkg::SPR_XCVR_HS3,
    parameter int PLL_CYC = `SPR_PLL_RST_CYC,
    parameter int PATH_CYC = `SPR_PATH_RST_CYC
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic transmit_sys_reset_in_i,
    input wire logic receive_sys_reset_in_i,
    input wire logic transmit_path_reset_in_i,
    input wire logic receive_path_reset_in_i,
    input wire logic tx_pll_lock_i,
    input wire logic rx_pll_lock_i,
    input wire logic tx_path_ready_i,
    input wire logic rx_path_ready_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic tx_pll_reset_o,
    output logic rx_pll_reset_o,
    output logic tx_path_reset_o,
    output logic rx_path_reset_o,
    output logic tx_reset_done_o,
    output logic rx_reset_done_o,
    output logic mgmt_active_o,
    output logic shared_pll_present_o,
    output logic pll_reconfig_reachable_o,
    output logic [1:0] refclk_present_o,
    output logic debug_ctrl_exposed_o,
    output logic [7:0] core_clk_div_o,
    output logic [7:0] usr_clk_div_o
);
    // build-time structure
    localparam bit MGMT_ON = MGMT_EN && !SUB_CORE; // RQ5
    localparam bit PLL_ON = SHARED_PLL_EN; // RQ1
    localparam bit RECONF_ON = MGMT_ON && PLL_ON && SHARED_PLL_SEL; // RQ3
    localparam logic [1:0] REFCLKS = (MGMT_ON && SHARED_PLL_SEL) || BOTH_PLL_SEL
        ? 2'h3 : (SHARED_PLL_SEL ? 2'h2 : 2'h1); // RQ4 RQ13
    localparam bit DBG_CTRL = DEBUG_EN && !MGMT_ON; // RQ2
    localparam logic [7:0] CORE_DIV = (DATA_WIDTH == spr_pkg::SPR_DW_64)
        ? `SPR_DIV_64B : `SPR_DIV_32B; // RQ7 RQ8 RQ9
    localparam logic [7:0] USR_DIV = (XCVR == spr_pkg::SPR_XCVR_UHS)
        ? `SPR_USR_DIV_UHS : `SPR_USR_DIV_HI; // RQ10 RQ11

    // two-flop synchronisers for the four reset inputs; wishbone is on mclk
    // so software resets need none (RQ14: no second domain remains)
    logic [3:0] rst_meta;
    logic [3:0] rst_sync;
    logic [3:0] rst_prev;
    wire [3:0] rst_pins = {receive_path_reset_in_i, transmit_path_reset_in_i,
        receive_sys_reset_in_i, transmit_sys_reset_in_i};

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 4'h0;
            rst_sync <= 4'h0;
            rst_prev <= 4'h0;
        end else begin
            rst_meta <= rst_pins; // RQ20
            rst_sync <= rst_meta;
            rst_prev <= rst_sync;
        end
    end

    // software control: a written 1 to an unmasked bit starts a sequence, bits self-clear
    logic [3:0] ctrl_pulse;
    logic [3:0] next_ctrl_pulse;
    logic [3:0] sw_mask;
    wire [3:0] pin_rise = rst_sync & ~rst_prev;
    wire [3:0] starts = pin_rise | ctrl_pulse;

    // wishbone slave: ack one cycle after strobe, dropped the next
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // a write lands on the edge at which the master sees ack, while it still holds
    wire wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && MGMT_ON;
    wire hit_ctrl = (wb_adr_i == `SPR_CTRL_OFS);
    wire hit_stat = (wb_adr_i == `SPR_STAT_OFS);
    wire hit_cfg = (wb_adr_i == `SPR_CFG_OFS);
    wire hit_div = (wb_adr_i == `SPR_DIV_OFS);

    spr_pkg::spr_seq_out_type tx_out;
    spr_pkg::spr_seq_out_type rx_out;
    spr_pkg::spr_seq_in_type tx_in;
    spr_pkg::spr_seq_in_type rx_in;

    wire [31:0] stat_word = {28'h0000000, rx_out.pll_reset, tx_out.pll_reset,
        rx_out.done, tx_out.done};
    wire [31:0] cfg_word = {24'h000000, REFCLKS, DBG_CTRL, RECONF_ON, PLL_ON,
        MGMT_ON, DATA_WIDTH};
    wire [31:0] div_word = {16'h0000, USR_DIV, CORE_DIV};
    wire [31:0] ctrl_word = {20'h00000, sw_mask, 8'h00};
    wire [31:0] rd_word = hit_ctrl ? ctrl_word : hit_stat ? stat_word
        : hit_cfg ? cfg_word : hit_div ? div_word : 32'h00000000;

    assign next_ctrl_pulse = (wb_wr && hit_ctrl && wb_sel_i[0])
        ? wb_dat_i[3:0] & ~sw_mask : 4'h0;

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_pulse <= `SPR_CTRL_RST;
            sw_mask <= `SPR_CTRL_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ctrl_pulse <= next_ctrl_pulse;
            if (wb_wr && hit_ctrl && wb_sel_i[1])
                sw_mask <= wb_dat_i[11:8];
            wb_ack_o <= wb_req;
            if (wb_req)
                wb_dat_o <= MGMT_ON ? rd_word : 32'h00000000;
        end
    end

    // one sequencer per direction, independent of each other
    assign tx_in = '{sys_req: starts[`SPR_CTRL_TX_SYS], path_req: starts[`SPR_CTRL_TX_PATH],
        pll_lock: tx_pll_lock_i, path_ready: tx_path_ready_i}; // RQ15
    assign rx_in = '{sys_req: starts[`SPR_CTRL_RX_SYS], path_req: starts[`SPR_CTRL_RX_PATH],
        pll_lock: rx_pll_lock_i, path_ready: rx_path_ready_i}; // RQ15

    spr_seq #(
        .PLL_CYC(PLL_CYC),
        .PATH_CYC(PATH_CYC)
    ) u_tx_seq (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .seq_i(tx_in),
        .seq_o(tx_out)
    ); // RQ12 RQ16

    spr_seq #(
        .PLL_CYC(PLL_CYC),
        .PATH_CYC(PATH_CYC)
    ) u_rx_seq (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .seq_i(rx_in),
        .seq_o(rx_out)
    ); // RQ12 RQ17

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_pll_reset_o <= 1'b0;
            rx_pll_reset_o <= 1'b0;
            tx_path_reset_o <= 1'b0;
            rx_path_reset_o <= 1'b0;
            tx_reset_done_o <= 1'b0;
            rx_reset_done_o <= 1'b0;
            mgmt_active_o <= 1'b0;
            shared_pll_present_o <= 1'b0;
            pll_reconfig_reachable_o <= 1'b0;
            refclk_present_o <= 2'h0;
            debug_ctrl_exposed_o <= 1'b0;
            core_clk_div_o <= 8'h00;
            usr_clk_div_o <= 8'h00;
        end else begin
            tx_pll_reset_o <= tx_out.pll_reset; // RQ18
            rx_pll_reset_o <= rx_out.pll_reset; // RQ18
            tx_path_reset_o <= tx_out.path_reset; // RQ16
            rx_path_reset_o <= rx_out.path_reset; // RQ17
            // done also masked while a start is in flight, so it drops at once
            tx_reset_done_o <= tx_out.done && !tx_in.sys_req && !tx_in.path_req; // RQ19
            rx_reset_done_o <= rx_out.done && !rx_in.sys_req && !rx_in.path_req; // RQ19
            mgmt_active_o <= MGMT_ON; // RQ5
            shared_pll_present_o <= PLL_ON; // RQ1
            pll_reconfig_reachable_o <= RECONF_ON; // RQ3
            refclk_present_o <= REFCLKS; // RQ4
            debug_ctrl_exposed_o <= DBG_CTRL; // RQ2
            core_clk_div_o <= CORE_DIV; // RQ7 RQ8
            usr_clk_div_o <= USR_DIV; // RQ10 RQ11
        end
    end

    tx_done_drop_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        tx_in.sys_req |=> !tx_reset_done_o) // RQ19
        else $error("tx done high after sequence start");

    rx_indep_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (rx_in.sys_req && !tx_in.sys_req && !tx_out.pll_reset) |=> ##1 !tx_pll_reset_o) // RQ15
        else $error("rx system reset reached tx pll");

    sync_delay_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(rst_sync[0]) |-> $past(transmit_sys_reset_in_i, 2)) // RQ20
        else $error("reset input skipped synchroniser");

    wb_ack_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wb_ack_o |=> !wb_ack_o) // RQ14
        else $error("ack held two cycles");

    reconf_gate_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pll_reconfig_reachable_o |-> mgmt_active_o && shared_pll_present_o) // RQ3
        else $error("reconfiguration reachable without management");

    sub_core_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        SUB_CORE |-> !mgmt_active_o) // RQ5
        else $error("management active in sub-core build");

    // pin edges: two sync flops; the edge detect adds no cycle
    sequence tx_sys_pin_s;
        !transmit_sys_reset_in_i ##1 transmit_sys_reset_in_i;
    endsequence

    sequence rx_sys_pin_s;
        !receive_sys_reset_in_i ##1 receive_sys_reset_in_i;
    endsequence

    sequence tx_path_pin_s;
        !transmit_path_reset_in_i ##1 transmit_path_reset_in_i;
    endsequence

    sequence rx_path_pin_s;
        !receive_path_reset_in_i ##1 receive_path_reset_in_i;
    endsequence

    tx_sys_pin_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ20
        tx_sys_pin_s |-> ##2 tx_in.sys_req)
        else $error("tx system reset pin did not start a sequence");

    rx_sys_pin_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ20
        rx_sys_pin_s |-> ##2 rx_in.sys_req)
        else $error("rx system reset pin did not start a sequence");

    tx_path_pin_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ20
        tx_path_pin_s |-> ##2 tx_in.path_req)
        else $error("tx path reset pin did not start a sequence");

    rx_path_pin_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ20
        rx_path_pin_s |-> ##2 rx_in.path_req)
        else $error("rx path reset pin did not start a sequence");

    // a start shows on the pins after the sequencer and output registers
    tx_sys_lat_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ18
        tx_in.sys_req |-> ##2 tx_pll_reset_o)
        else $error("tx pll reset late after system start");

    rx_sys_lat_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ18
        rx_in.sys_req |-> ##2 rx_pll_reset_o)
        else $error("rx pll reset late after system start");

    tx_path_lat_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ16
        tx_in.path_req && !tx_in.sys_req |-> ##2 tx_path_reset_o && !tx_pll_reset_o)
        else $error("tx path-only start wrong on outputs");

    rx_path_lat_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ17
        rx_in.path_req && !rx_in.sys_req |-> ##2 rx_path_reset_o && !rx_pll_reset_o)
        else $error("rx path-only start wrong on outputs");

    // datapath must be held whenever its pll is held
    tx_pll_path_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ18
        tx_pll_reset_o |-> tx_path_reset_o)
        else $error("tx pll reset without path reset");

    rx_pll_path_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ18
        rx_pll_reset_o |-> rx_path_reset_o)
        else $error("rx pll reset without path reset");

    tx_done_path_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ19
        !(tx_reset_done_o && tx_path_reset_o))
        else $error("tx done while path reset held");

    rx_done_path_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ19
        !(rx_reset_done_o && rx_path_reset_o))
        else $error("rx done while path reset held");

    // done only follows a completed datapath reset
    tx_done_ready_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ16
        $rose(tx_reset_done_o) |-> $past(tx_path_ready_i, 2))
        else $error("tx done without path ready");

    rx_done_ready_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ17
        $rose(rx_reset_done_o) |-> $past(rx_path_ready_i, 2))
        else $error("rx done without path ready");

    tx_path_drop_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ19
        tx_in.path_req |=> !tx_reset_done_o)
        else $error("tx done high after path start");

    rx_done_drop_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ19
        rx_in.sys_req || rx_in.path_req |=> !rx_reset_done_o)
        else $error("rx done high after sequence start");

    tx_indep_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ15
        (tx_in.sys_req && !rx_in.sys_req && !rx_out.pll_reset) |=> ##1 !rx_pll_reset_o)
        else $error("tx system reset reached rx pll");

    // bus and software starts
    wb_req_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ14
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");

    ctrl_mask_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ16
        (ctrl_pulse & $past(sw_mask)) == 4'h0)
        else $error("masked software start went through");

    ctrl_pulse_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ16
        ctrl_pulse != 4'h0 |=> ctrl_pulse == 4'h0)
        else $error("software start longer than one cycle");

    // build-time outputs never move once set
    core_div_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ7 RQ8
        core_clk_div_o != 8'h00 |=> $stable(core_clk_div_o))
        else $error("core clock divide changed");

    usr_div_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ10 RQ11
        usr_clk_div_o != 8'h00 |=> $stable(usr_clk_div_o))
        else $error("user clock divide changed");

    refclk_a: assert property (@(posedge mclk_i) disable iff (!nrst_i) // RQ4
        refclk_present_o != 2'h0 |=> $stable(refclk_present_o))
        else $error("reference clock set changed");
endmodule

// file: dv/spr_xcvr_model.sv
module spr_xcvr_model #(
    parameter int LOCK_CYC = 4,
    parameter int READY_CYC = 3
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic pll_reset_i,
    input wire logic path_reset_i,
    output logic pll_lock_o,
    output logic path_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int lock_cnt;
    int ready_cnt;
    // lock is lost on pll reset and only returns after a settle time
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lock_cnt <= 0;
        end else if (pll_reset_i) begin
            lock_cnt <= 0;
        end else if (lock_cnt < LOCK_CYC) begin
            lock_cnt <= lock_cnt + 1;
        end
    end
    // datapath cannot finish its reset while the pll is unlocked
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_cnt <= 0;
        end else if (path_reset_i || !pll_lock_o) begin
            ready_cnt <= 0;
        end else if (ready_cnt < READY_CYC) begin
            ready_cnt <= ready_cnt + 1;
        end
    end
    assign pll_lock_o = (lock_cnt >= LOCK_CYC);
    assign path_ready_o = (ready_cnt >= READY_CYC);
endmodule

// file: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i;
    logic nrst_i;
    logic [3:0] pins;
    logic [7:0] adr;
    logic [31:0] wdat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
    logic [31:0] rd;
    wire [31:0] rdat;
    wire ack;
    wire [1:0] pll_w;
    wire [1:0] path_w;
    wire [1:0] done_w;
    wire [1:0] lock_w;
    wire [1:0] rdy_w;
    wire mgmt;
    wire shp;
    wire reach;
    wire dbg;
    wire [7:0] cdiv;
    wire [7:0] udiv;
    wire [1:0] refc;
    int err_total;
    int n_compared;

    spr_top #(.PLL_CYC(2), .PATH_CYC(2)) uut (
        .mclk_i(mclk_i), .nrst_i(nrst_i),
        .transmit_sys_reset_in_i(pins[0]), .receive_sys_reset_in_i(pins[1]),
        .transmit_path_reset_in_i(pins[2]), .receive_path_reset_in_i(pins[3]),
        .tx_pll_lock_i(lock_w[0]), .rx_pll_lock_i(lock_w[1]),
        .tx_path_ready_i(rdy_w[0]), .rx_path_ready_i(rdy_w[1]),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_pll_reset_o(pll_w[0]), .rx_pll_reset_o(pll_w[1]),
        .tx_path_reset_o(path_w[0]), .rx_path_reset_o(path_w[1]),
        .tx_reset_done_o(done_w[0]), .rx_reset_done_o(done_w[1]),
        .mgmt_active_o(mgmt), .shared_pll_present_o(shp),
        .pll_reconfig_reachable_o(reach), .refclk_present_o(refc),
        .debug_ctrl_exposed_o(dbg), .core_clk_div_o(cdiv), .usr_clk_div_o(udiv));

    // tx side settles slowly, rx side promptly
    spr_xcvr_model #(.LOCK_CYC(6), .READY_CYC(4)) tx_far (.mclk_i(mclk_i),
        .nrst_i(nrst_i), .pll_reset_i(pll_w[0]), .path_reset_i(path_w[0]),
        .pll_lock_o(lock_w[0]), .path_ready_o(rdy_w[0]));
    spr_xcvr_model #(.LOCK_CYC(1)) rx_far (.mclk_i(mclk_i),
        .nrst_i(nrst_i), .pll_reset_i(pll_w[1]), .path_reset_i(path_w[1]),
        .pll_lock_o(lock_w[1]), .path_ready_o(rdy_w[1]));

    task automatic finish_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until ack is seen at a rising edge; data taken at that edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk_i);
        adr <= a;
        we <= w;
        wdat <= d;
        sel <= s;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        check("wb_ack", ack, 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic watch(input int pin, input int d, input logic exp_pll);
        int n;
        logic low_seen, pll_seen, path_seen, other_seen, overlap;
        n = 0;
        {low_seen, pll_seen, path_seen, other_seen, overlap} = 5'h00;
        if (pin >= 0) begin
            @(posedge mclk_i);
            pins[pin] <= 1'b1;
        end
        while (n < 300 && !(done_w[d] === 1'b1 && path_seen)) begin
            @(posedge mclk_i);
            if (n == 4) pins <= 4'h0;
            @(negedge mclk_i);
            n++;
            if (done_w[d] !== 1'b1) low_seen = 1'b1;
            if (pll_w[d] === 1'b1) pll_seen = 1'b1;
            if (path_w[d] === 1'b1) path_seen = 1'b1;
            if (pll_w[1-d] !== 1'b0 || path_w[1-d] !== 1'b0) other_seen = 1'b1;
            if (path_w[d] === 1'b1 && done_w[d] === 1'b1) overlap = 1'b1;
        end
        if (pin >= 0) check("done_low", low_seen, 1'b1);
        check("pll_reset", pll_seen, exp_pll);
        check("path_reset", path_seen, 1'b1);
        check("other_dir", other_seen, 1'b0);
        check("done_overlap", overlap, 1'b0);
        check("done_high", done_w[d], 1'b1);
    endtask

    task automatic t_build();
        repeat (3) @(posedge mclk_i);
        check("core_div", cdiv, 8'h28);
        check("refclk", refc, 2'h3);
        check("usr_div", udiv, 8'h21);
        check("mgmt", mgmt, 1'b1);
        check("shared_pll", shp, 1'b1);
        check("reconfig", reach, 1'b1);
        check("debug", dbg, 1'b0);
    endtask

    task automatic t_sys();
        watch(0, 0, 1'b1);
        watch(1, 1, 1'b1);
    endtask

    task automatic t_path();
        watch(3, 1, 1'b0);
        watch(2, 0, 1'b0);
    endtask

    task automatic t_regs();
        wb(8'h0C, 1'b0, 32'h0, 4'hF);
        check("div_reg", rd, 32'h00002128);
        wb(8'h10, 1'b0, 32'h0, 4'hF);
        check("unmapped", rd, 32'h0);
        wb(8'h00, 1'b1, 32'h00000200, 4'h2);
        wb(8'h00, 1'b0, 32'h0, 4'hF);
        check("ctrl_mask", rd, 32'h00000200);
        wb(8'h00, 1'b1, 32'h00000002, 4'h1);
        repeat (3) @(posedge mclk_i);
        check("masked_pll", pll_w[1], 1'b0);
        check("masked_done", done_w[1], 1'b1);
        wb(8'h00, 1'b1, 32'h00000000, 4'h2);
        wb(8'h00, 1'b1, 32'h00000002, 4'h1);
        watch(-1, 1, 1'b1);
        wb(8'h04, 1'b0, 32'h0, 4'hF);
        check("status", rd, 32'h00000003);
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        finish_test();
    end

    initial begin
        err_total = 0;
        n_compared = 0;
        nrst_i = 1'b0;
        pins = 4'h0;
        adr = 8'h00;
        wdat = 32'h0;
        sel = 4'hF;
        {we, cyc, stb} = 3'h0;
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_build();
        t_sys();
        t_path();
        t_regs();
        finish_test();
    end
endmodule
